// file: logic/dsf_pkg.sv
// Constants of the slave diagnostic frame builder.
// Assumes a Wishbone classic host and a byte-wide link transmitter.
`default_nettype none
package dsf_pkg;
   // Register byte addresses
   localparam logic [9:0] ADR_FLAGS = 10'h000;
   localparam logic [9:0] ADR_MADDR = 10'h004;
   localparam logic [9:0] ADR_IDENT = 10'h008;
   localparam logic [9:0] ADR_MSG   = 10'h00c;
   localparam logic [9:0] ADR_UPOS  = 10'h010;
   localparam logic [9:0] ADR_STAT  = 10'h014;
   localparam logic [9:0] ADR_RQ    = 10'h018;
   // Process image window, one byte per word
   localparam logic [1:0] IMG_PAGE  = 2'h1;
   localparam int         IMG_DEPTH = 64;
   // Station flag positions in the flag register
   localparam int F_NRDY  = 0;
   localparam int F_CFG   = 1;
   localparam int F_EXT   = 2;
   localparam int F_UNSUP = 3;
   localparam int F_WPRM  = 4;
   localparam int F_NPRM  = 5;
   localparam int F_STAT  = 6;
   localparam int F_RMON  = 7;
   localparam int F_FRZ   = 8;
   localparam int F_SYNC  = 9;
   localparam int F_OVF   = 10;
   localparam int FLAG_W  = 11;
   // Reset values
   localparam logic [FLAG_W-1:0] RST_FLAGS = 11'h001;
   localparam logic [7:0]        RST_MADDR = 8'hff;
   localparam logic [15:0]       RST_IDENT = 16'h0000;
   localparam logic [5:0]        RST_UPOS  = 6'h00;
   // Device-specific header: length 10, code 00
   localparam logic [7:0] DEV_HDR = 8'h0a;
   // Message codes
   localparam logic [7:0] MSG_NONE    = 8'h00;
   localparam logic [7:0] MSG_PRM_LEN = 8'h12;
   localparam logic [7:0] MSG_CFG_LEN = 8'h13;
   localparam logic [7:0] MSG_CFG_ENT = 8'h14;
   localparam logic [7:0] MSG_BUF     = 8'h15;
   localparam logic [7:0] MSG_NO_CFG  = 8'h16;
   localparam logic [7:0] MSG_CMP     = 8'h17;
   localparam logic [7:0] MSG_USER    = 8'h40;
   // Frame byte indexes
   localparam logic [3:0] IDX_FIRST = 4'h0;
   localparam logic [3:0] IDX_HDR   = 4'h6;
   localparam logic [3:0] IDX_USR   = 4'hb;
   localparam logic [3:0] IDX_LAST  = 4'hf;
   // Host diagnostic status byte
   localparam int         UD_VALID  = 0;
   localparam int         UD_DELETE = 1;
   localparam logic [7:0] UD_IGNORE = 8'h03;
   typedef enum {SND_IDLE, SND_BUSY} dsf_snd_t;
endpackage
`default_nettype wire

// file: logic/dsf_sticky.sv
// Sticky event flag, set has priority over clear.
// Assumes set and clear are single-cycle pulses on the same clock.
`default_nettype none
module dsf_sticky (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic clr,
   output logic      flag
);
   // Set wins so an event in the clearing cycle is kept
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: logic/dsf_byte_sel.sv
// Picks one byte of the 16-byte diagnostic frame by index.
// Assumes all field inputs are stable while the caller samples.
`default_nettype none
module dsf_byte_sel #(
   parameter bit IDENT_HI_FIRST = 1'b1
) (
   input  wire logic [3:0]  idx,
   input  wire logic [7:0]  st0,
   input  wire logic [7:0]  st1,
   input  wire logic [7:0]  st2,
   input  wire logic [7:0]  maddr,
   input  wire logic [15:0] ident,
   input  wire logic [7:0]  msg,
   input  wire logic [39:0] user,
   output logic      [7:0]  byte_o
);
   import dsf_pkg::*;
   logic [7:0] frame [16];
   // Standard part
   assign frame[0]  = st0;
   assign frame[1]  = st1;
   assign frame[2]  = st2;
   assign frame[3]  = maddr;
   assign frame[4]  = IDENT_HI_FIRST ? ident[15:8] : ident[7:0];
   assign frame[5]  = IDENT_HI_FIRST ? ident[7:0] : ident[15:8];
   // Device-specific part, reserved bytes zero
   assign frame[6]  = DEV_HDR;
   assign frame[7]  = msg;
   assign frame[8]  = 8'h00;
   assign frame[9]  = 8'h00;
   assign frame[10] = 8'h00;
   assign frame[11] = user[7:0];
   assign frame[12] = user[15:8];
   assign frame[13] = user[23:16];
   assign frame[14] = user[31:24];
   assign frame[15] = user[39:32];
   assign byte_o    = frame[idx];
endmodule
`default_nettype wire

// file: logic/dsf_diag_frame.sv
// Slave diagnostic frame builder with Wishbone register access.
// Assumes a byte-wide transmitter with valid/ready on the link side.
//
// Functional notes
// - Frame is sent on master request and on each write of an error message code; station error flag writes send none.
// - Frame is 16 bytes: standard bytes 0-5, device bytes 6-15.
// - Byte 0 bits 0,5,7 zero; bits 1,2,3,4,6 carry station errors.
// - Byte 1: new param, static, fixed one, monitor, freeze, sync; bit 7 zero.
// - Byte 2 bit 7 flags overflow, bits 0-6 reserved zero.
// - Byte 3 holds master address latched at parametrization.
// - Byte 6 holds length 10 in bits 0-5 and code zero above.
// - Byte 7 holds one message code, 12h-17h errors or 40h user.
// - Bytes 11-15 come live from the host process image.
// - The five user bytes follow their governing status byte.
// - Rising valid bit in the status byte sends the user message.
// - Status value 03h is ignored.
// - The six-byte block sits at a configurable image position.
`default_nettype none
module dsf_diag_frame #(
   parameter bit IDENT_HI_FIRST = 1'b1
) (
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [9:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic        DIAG_REQ,
   input  wire logic        PRM_STB,
   input  wire logic [7:0]  PRM_MASTER,
   output logic      [7:0]  FRM_DATA,
   output logic             FRM_VALID,
   output logic             FRM_FIRST,
   output logic             FRM_LAST,
   input  wire logic        FRM_READY
);
   import dsf_pkg::*;

   // Byte-lane merge for register writes
   function automatic logic [31:0] wmask(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   // True for the error message codes
   function automatic logic is_err(input logic [7:0] code);
      return (code >= MSG_PRM_LEN) && (code <= MSG_CMP);
   endfunction

   logic [FLAG_W-1:0] flags;
   logic [7:0]        maddr;
   logic [15:0]       ident;
   logic [7:0]        msg_code;
   logic [5:0]        upos;
   logic [15:0]       sent;
   logic [7:0]        img [IMG_DEPTH];
   logic              ud_prev;
   dsf_snd_t          state;
   logic [3:0]        frm_idx;
   logic              pend_req;
   logic              pend_err;
   logic              pend_usr;

   // Bus request decode
   wire        wb_req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   // Writes land at the edge where the master samples ack
   wire        wb_wr     = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I;
   wire        hit_flags = (WB_ADR_I == ADR_FLAGS);
   wire        hit_maddr = (WB_ADR_I == ADR_MADDR);
   wire        hit_ident = (WB_ADR_I == ADR_IDENT);
   wire        hit_msg   = (WB_ADR_I == ADR_MSG);
   wire        hit_upos  = (WB_ADR_I == ADR_UPOS);
   wire        hit_stat  = (WB_ADR_I == ADR_STAT);
   wire        hit_rq    = (WB_ADR_I == ADR_RQ);
   wire        hit_img   = (WB_ADR_I[9:8] == IMG_PAGE);
   wire [5:0]  img_adr   = WB_ADR_I[7:2];

   // Write strobes per register
   wire        wr_flags  = wb_wr & hit_flags;
   wire        wr_maddr  = wb_wr & hit_maddr;
   wire        wr_ident  = wb_wr & hit_ident;
   wire        wr_msg    = wb_wr & hit_msg & WB_SEL_I[0];
   wire        wr_upos   = wb_wr & hit_upos & WB_SEL_I[0];
   wire        wr_rq     = wb_wr & hit_rq & WB_SEL_I[0] & WB_DAT_I[0];
   wire        wr_img    = wb_wr & hit_img & WB_SEL_I[0];

   // Status word: frame count and pending events
   wire [31:0] stat_word = {sent, 12'h000, pend_usr, pend_err,
                            pend_req, (state == SND_BUSY)};

   // Read data selection, unmapped reads return zero
   wire [31:0] rd_mux =
      hit_flags ? {21'h000000, flags} :
      hit_maddr ? {24'h000000, maddr} :
      hit_ident ? {16'h0000, ident} :
      hit_msg   ? {24'h000000, msg_code} :
      hit_upos  ? {26'h0000000, upos} :
      hit_stat  ? stat_word :
      hit_img   ? {24'h000000, img[img_adr]} :
      32'h00000000;

   // Merged values for byte-lane writes
   wire [31:0] flags_w = wmask({21'h000000, flags}, WB_DAT_I, WB_SEL_I);
   wire [31:0] maddr_w = wmask({24'h000000, maddr}, WB_DAT_I, WB_SEL_I);
   wire [31:0] ident_w = wmask({16'h0000, ident}, WB_DAT_I, WB_SEL_I);

   // Single-cycle ack one edge after the request is seen
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= (wb_req & ~WB_WE_I) ? rd_mux : 32'h00000000;
      end
   end

   // Station flags, ident and image position
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         flags <= RST_FLAGS;
         ident <= RST_IDENT;
         upos  <= RST_UPOS;
      end else begin
         if (wr_flags) flags <= flags_w[FLAG_W-1:0];
         if (wr_ident) ident <= ident_w[15:0];
         if (wr_upos)  upos  <= WB_DAT_I[5:0];
      end
   end

   // Master address caught at parametrization
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         maddr <= RST_MADDR;
      end else if (PRM_STB) begin
         maddr <= PRM_MASTER;
      end else if (wr_maddr) begin
         maddr <= maddr_w[7:0];
      end
   end

   // Process image, host writes bytes here
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         for (int i = 0; i < IMG_DEPTH; i++) begin
            img[i] <= 8'h00;
         end
      end else if (wr_img) begin
         img[img_adr] <= WB_DAT_I[7:0];
      end
   end

   // Status byte and the five user bytes right behind it
   wire [7:0]  ud_stat = img[upos];
   wire [39:0] ud_user = {img[6'(upos + 6'd5)], img[6'(upos + 6'd4)],
                          img[6'(upos + 6'd3)], img[6'(upos + 6'd2)],
                          img[6'(upos + 6'd1)]};
   wire        ud_ok   = (ud_stat != UD_IGNORE);
   wire        ud_rise = ud_ok & ud_stat[UD_VALID] & ~ud_prev;
   wire        ud_del  = ud_ok & ud_stat[UD_DELETE];

   // Valid bit history, ignored values leave it alone
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ud_prev <= 1'b0;
      end else if (ud_ok) begin
         ud_prev <= ud_stat[UD_VALID];
      end
   end

   // Message code: errors, user valid, or deleted
   wire err_set = wr_msg & is_err(WB_DAT_I[7:0]);
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         msg_code <= MSG_NONE;
      end else if (wr_msg) begin
         msg_code <= WB_DAT_I[7:0];
      end else if (ud_rise) begin
         msg_code <= MSG_USER;
      end else if (ud_del && msg_code == MSG_USER) begin
         msg_code <= MSG_NONE;
      end
   end

   // Station status bytes with fixed bits
   wire [7:0] st0 = {1'b0, flags[F_WPRM], 1'b0, flags[F_UNSUP],
                     flags[F_EXT], flags[F_CFG], flags[F_NRDY],
                     1'b0};
   wire [7:0] st1 = {2'b00, flags[F_SYNC], flags[F_FRZ], flags[F_RMON],
                     1'b1, flags[F_STAT], flags[F_NPRM]};
   wire [7:0] st2 = {flags[F_OVF], 7'h00};

   // Send triggers and frame walk control
   wire       any_pend = pend_req | pend_err | pend_usr;
   wire       start    = (state == SND_IDLE) & any_pend;
   wire       take     = FRM_VALID & FRM_READY;
   wire       at_last  = (frm_idx == IDX_LAST);
   wire [3:0] sel_idx  = start ? IDX_FIRST : 4'(frm_idx + 4'd1);
   wire [7:0] sel_byte;

   // Pending events, cleared when a frame starts
   dsf_sticky u_pend_req (
      .clk  (REF_CLK),
      .rst  (SYS_RST),
      .set  (DIAG_REQ | wr_rq),
      .clr  (start),
      .flag (pend_req)
   );
   dsf_sticky u_pend_err (
      .clk  (REF_CLK),
      .rst  (SYS_RST),
      .set  (err_set),
      .clr  (start),
      .flag (pend_err)
   );
   dsf_sticky u_pend_usr (
      .clk  (REF_CLK),
      .rst  (SYS_RST),
      .set  (ud_rise),
      .clr  (start),
      .flag (pend_usr)
   );

   // Frame byte for the next index
   dsf_byte_sel #(
      .IDENT_HI_FIRST (IDENT_HI_FIRST)
   ) u_sel (
      .idx    (sel_idx),
      .st0    (st0),
      .st1    (st1),
      .st2    (st2),
      .maddr  (maddr),
      .ident  (ident),
      .msg    (msg_code),
      .user   (ud_user),
      .byte_o (sel_byte)
   );

   // Byte sender, data held until the link takes it
   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state     <= SND_IDLE;
         frm_idx   <= IDX_FIRST;
         FRM_DATA  <= 8'h00;
         FRM_VALID <= 1'b0;
         FRM_FIRST <= 1'b0;
         FRM_LAST  <= 1'b0;
         sent      <= 16'h0000;
      end else if (start) begin
         state     <= SND_BUSY;
         frm_idx   <= IDX_FIRST;
         FRM_DATA  <= sel_byte;
         FRM_VALID <= 1'b1;
         FRM_FIRST <= 1'b1;
         FRM_LAST  <= 1'b0;
      end else if (state == SND_BUSY && take) begin
         if (at_last) begin
            state     <= SND_IDLE;
            FRM_VALID <= 1'b0;
            FRM_LAST  <= 1'b0;
            sent      <= 16'(sent + 16'd1);
         end else begin
            frm_idx   <= sel_idx;
            FRM_DATA  <= sel_byte;
            FRM_FIRST <= 1'b0;
            FRM_LAST  <= (sel_idx == IDX_LAST);
         end
      end
   end

   // Checks on the produced frame, its sources and the bus ack
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_take;
      FRM_VALID && FRM_READY;
   endsequence

   sequence s_idle_req;
      (state == SND_IDLE) && DIAG_REQ;
   endsequence

   AST_REQ_SENDS: assert property (
      s_idle_req |-> ##[1:2] (FRM_VALID && FRM_FIRST))
      else $error("Request did not start a frame");

   AST_ERR_SENDS: assert property (
      (err_set && state == SND_IDLE) |-> ##[1:2] (FRM_VALID && FRM_FIRST))
      else $error("Error code did not start a frame");

   AST_LAST_IDX: assert property (
      FRM_VALID |-> (FRM_LAST == (frm_idx == IDX_LAST)))
      else $error("Last marker not on byte fifteen");

   AST_END: assert property (
      (s_take ##0 FRM_LAST) |=> !FRM_VALID)
      else $error("Frame ran past byte fifteen");

   AST_ST0: assert property (
      (FRM_VALID && frm_idx == IDX_FIRST) |->
         (FRM_DATA[0] == 1'b0 && FRM_DATA[5] == 1'b0 && FRM_DATA[7] == 1'b0))
      else $error("Byte 0 fixed bits wrong");

   AST_ST1: assert property (
      (FRM_VALID && frm_idx == 4'd1) |-> (FRM_DATA[2] && !FRM_DATA[7]))
      else $error("Byte 1 fixed bits wrong");

   AST_ST2: assert property (
      (FRM_VALID && frm_idx == 4'd2) |->
         (FRM_DATA == {flags[F_OVF], 7'h00}))
      else $error("Byte 2 wrong");

   AST_MADDR: assert property (
      PRM_STB |=> (maddr == $past(PRM_MASTER)))
      else $error("Master address not latched");

   AST_HDR: assert property (
      (FRM_VALID && frm_idx == IDX_HDR) |-> (FRM_DATA == DEV_HDR))
      else $error("Header byte wrong");

   AST_USER_CODE: assert property (
      (ud_rise && !wr_msg) |=> (msg_code == MSG_USER) && pend_usr)
      else $error("User diagnostic not flagged");

   AST_IGNORE: assert property (
      (ud_stat == UD_IGNORE) |-> !ud_rise)
      else $error("Ignored status byte triggered");

   AST_RSVD: assert property (
      (FRM_VALID && frm_idx >= 4'd8 && frm_idx < IDX_USR) |->
         (FRM_DATA == 8'h00))
      else $error("Reserved byte not zero");

   AST_HOLD: assert property (
      (FRM_VALID && !FRM_READY) |=> (FRM_VALID && $stable(FRM_DATA)))
      else $error("Byte dropped before taken");

   AST_ACK: assert property (
      (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
      else $error("Bus ack timing wrong");

endmodule
`default_nettype wire

// file: tb/dsf_master_model.sv
// Link-side model of the bus master: takes frame bytes, keeps the last whole frame.
// Assumes a byte moves when valid and ready are both high at a rising edge.
`default_nettype none
module dsf_master_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       slow,
   input  wire logic [7:0] data,
   input  wire logic       valid,
   input  wire logic       first,
   input  wire logic       last,
   output logic            ready,
   output logic [7:0]      frm [16],
   output int              frames,
   output int              errs
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] buf_q [16];
   int         idx;
   // Take bytes, stalling every other cycle when slow, and check the framing marks
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ready <= 1'b0;
         idx <= 0;
         frames <= 0;
         errs <= 0;
      end else begin
         ready <= slow ? ~ready : 1'b1;
         if (valid && ready) begin
            buf_q[idx] <= data;
            if ((first !== (idx == 0)) || (last !== (idx == 15))) begin
               errs <= errs + 1;
            end
            idx <= (idx == 15) ? 0 : idx + 1;
            if (idx == 15) begin
               for (int k = 0; k < 15; k++) frm[k] <= buf_q[k];
               frm[15] <= data;
               frames <= frames + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/dsf_diag_frame_bench.sv
// Self-checking bench of the slave diagnostic frame builder.
// Assumes the master model in dsf_master_model.sv and the dsf_pkg constants.
`default_nettype none
module dsf_diag_frame_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import dsf_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [9:0]  adr = 10'h000;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic        ack, diag_req = 1'b0, prm_stb = 1'b0, slow = 1'b0;
   logic [7:0]  prm_m = 8'h00, fdata;
   logic        fvalid, ffirst, flast, fready;
   logic [7:0]  frm [16];
   int          frames, errs, base;
   int          bad_count = 0, comparisons = 0;
   logic [10:0] s_flags = RST_FLAGS;
   logic [7:0]  s_maddr = RST_MADDR, s_msg = MSG_NONE, s_img [64];
   logic [15:0] s_ident = RST_IDENT;
   logic [5:0]  s_upos = RST_UPOS;
   logic [31:0] lfsr = 32'h00011da4;
   logic [7:0]  codes [6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
   // 125 MHz clock
   always #4 clk = ~clk;
   dsf_diag_frame dut_u (.REF_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .DIAG_REQ(diag_req), .PRM_STB(prm_stb), .PRM_MASTER(prm_m),
      .FRM_DATA(fdata), .FRM_VALID(fvalid), .FRM_FIRST(ffirst), .FRM_LAST(flast),
      .FRM_READY(fready));
   dsf_master_model mdl_u (.clk(clk), .rst(rst), .slow(slow), .data(fdata),
      .valid(fvalid), .first(ffirst), .last(flast), .ready(fready), .frm(frm),
      .frames(frames), .errs(errs));
   // Verdict and end of run
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check32(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   // Expected frame byte from the shadow state
   function automatic logic [7:0] exp_byte(input int i);
      case (i)
         0: return {1'b0, s_flags[F_WPRM], 1'b0, s_flags[F_UNSUP], s_flags[F_EXT],
                    s_flags[F_CFG], s_flags[F_NRDY], 1'b0};
         1: return {2'b00, s_flags[F_SYNC], s_flags[F_FRZ], s_flags[F_RMON], 1'b1,
                    s_flags[F_STAT], s_flags[F_NPRM]};
         2: return {s_flags[F_OVF], 7'h00};
         3: return s_maddr;
         4: return s_ident[15:8];
         5: return s_ident[7:0];
         6: return 8'h0a;
         7: return s_msg;
         8, 9, 10: return 8'h00;
         default: return s_img[6'(s_upos + 6'(i - 10))];
      endcase
   endfunction
   // One classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      check32(rdat, e);
   endtask
   // One-cycle strobe: parametrization when prm is set, else master request
   task automatic pulse(input bit prm);
      @(posedge clk);
      if (prm) begin
         prm_stb <= 1'b1;
      end else begin
         diag_req <= 1'b1;
      end
      @(posedge clk);
      prm_stb <= 1'b0;
      diag_req <= 1'b0;
   endtask
   // Wait for frames to arrive, then compare the last one byte by byte
   task automatic frame_chk(input int n);
      int t;
      t = 0;
      while (frames != base + n && t < 600) begin
         @(posedge clk);
         t++;
      end
      check32(frames, base + n);
      if (frames != base + n) begin
         report_and_stop();
      end else begin
         for (int i = 0; i < 16; i++) check32(frm[i], exp_byte(i));
      end
   endtask
   initial begin
      for (int i = 0; i < 64; i++) s_img[i] = 8'h00;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // Reset values and an unmapped read
      rd_chk(ADR_FLAGS, 32'(RST_FLAGS));
      rd_chk(ADR_MADDR, 32'(RST_MADDR));
      rd_chk(ADR_IDENT, 32'h0);
      rd_chk(ADR_MSG, 32'h0);
      rd_chk(10'h01c, 32'h0);
      $display("test reset done");
      // Random station flags and ident, master requests, one doubled in mid-frame
      for (int k = 0; k < 6; k++) begin
         s_flags = 11'(rnd());
         s_ident = 16'(rnd());
         slow <= k[0];
         wb(1'b1, ADR_FLAGS, 32'(s_flags));
         wb(1'b1, ADR_IDENT, 32'(s_ident));
         rd_chk(ADR_FLAGS, 32'(s_flags));
         base = frames;
         pulse(1'b0);
         if (k == 3) begin
            repeat (4) @(posedge clk);
            pulse(1'b0);
         end
         frame_chk((k == 3) ? 2 : 1);
      end
      $display("test request done");
      // Parametrization latches master address; software request sends it
      prm_m <= 8'(rnd());
      pulse(1'b1);
      s_maddr = prm_m;
      rd_chk(ADR_MADDR, 32'(s_maddr));
      base = frames;
      wb(1'b1, ADR_RQ, 32'h1);
      frame_chk(1);
      $display("test master address done");
      // Every error code sends a frame carrying it
      for (int k = 0; k < 6; k++) begin
         s_msg = codes[k];
         base = frames;
         wb(1'b1, ADR_MSG, 32'(codes[k]));
         frame_chk(1);
      end
      $display("test codes done");
      // User block at a random image position, ignored status, then valid edge
      s_upos = 6'(rnd());
      wb(1'b1, ADR_UPOS, 32'(s_upos));
      rd_chk(ADR_UPOS, 32'(s_upos));
      for (int j = 1; j < 6; j++) begin
         s_img[6'(s_upos + 6'(j))] = 8'(rnd());
         wb(1'b1, 10'h100 + 10'(4 * int'(6'(s_upos + 6'(j)))), 32'(s_img[6'(s_upos + 6'(j))]));
      end
      base = frames;
      wb(1'b1, 10'h100 + 10'(4 * int'(s_upos)), 32'(UD_IGNORE));
      repeat (40) @(posedge clk);
      check32(frames, base);
      wb(1'b1, 10'h100 + 10'(4 * int'(s_upos)), 32'h1);
      s_msg = MSG_USER;
      frame_chk(1);
      // Live user bytes follow host changes
      s_img[6'(s_upos + 6'(5))] = 8'(rnd());
      wb(1'b1, 10'h100 + 10'(4 * int'(6'(s_upos + 6'(5)))), 32'(s_img[6'(s_upos + 6'(5))]));
      base = frames;
      pulse(1'b0);
      frame_chk(1);
      // Delete bit withdraws the user message code
      wb(1'b1, 10'h100 + 10'(4 * int'(s_upos)), 32'h2);
      s_msg = MSG_NONE;
      base = frames;
      pulse(1'b0);
      frame_chk(1);
      $display("test user done");
      rd_chk(ADR_STAT, {16'(frames), 16'h0000});
      check32(errs, 0);
      report_and_stop();
   end
endmodule
`default_nettype wire
